// ---- logic/eepfe_front_end.sv ----
// Purpose: Pin level front end of a 1 Mbit two-wire serial EEPROM slave
// Assumes: scl from the master clocks the bit engine; mclk runs the
//          write cycle timer and standby; srst is the power-on clear
// Notes:   Bytes are stored at their acknowledge slot; a stop after an
//          accepted data byte then starts the internal write cycle
// Operation
// - The array holds 128K bytes of 8 bits, one byte per address.
// - An optional 256 byte identification page exists and can be locked read-only until the next power-on clear.
// - Bits are captured on rising scl and driven out after falling scl.
// - The data pin is only ever pulled low or released.
// - The two chip-select pins give the expected select code bits b3 and b2.
// - Chip-select pins left open count as zero.
// - With write inhibit high no array location is changed.
// - With write inhibit low or open, array writes go ahead.
// - With write inhibit high, select and address bytes get an ack and data bytes a nack.
// - Until the power-on clear releases the bus is ignored, then the device resets into standby.
// - When the power-on clear asserts again the device stops answering the bus.
// - A stop with no write armed or running leaves the device in standby, where the master must leave it.
// - The select byte's upper nibble is the device type, 1011b for the page, and bit one is the top address bit.
// - Select byte bit zero chooses read when one and write when zero.
// - A select code that does not match gets no ack and the device goes idle.
// - During an internal write cycle the data pin stays released and the bus is ignored.
`timescale 1ns/1ps
module eepfe_front_end
	import eepfe_pkg::*;
#(
	parameter int WR_CYC  = WR_CYCLES,
	parameter bit ID_PAGE = 1'b1
) (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	input  wire logic chip_select_pin_low,
	input  wire logic chip_select_pin_high,
	input  wire logic write_inhibit_in,
	output logic      write_busy,
	output logic      standby
);
	localparam int CNT_W = $clog2(WR_CYC + 1);

	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [DATA_W-1:0] idp [ID_WORDS];

	// Link domain state
	eepfe_state_t      state;
	logic [BIT_W-1:0]  bit_cnt;
	logic [DATA_W-1:0] shreg;
	logic [DATA_W-1:0] rd_byte;
	logic [ADDR_W-1:0] addr;
	logic              sel_id;
	logic              id_lock;
	logic              wr_armed;
	logic              wi_ack;
	logic              start_seen;
	logic              start_last;
	logic              por_l1, por_l2;
	logic              busy_l1, busy_l2;
	logic              wi_l1, wi_l2;
	logic [1:0]        cs_l1, cs_l2;
	logic              ack_now;
	logic              sel_ok;
	logic              wr_ok;
	logic              mem_we;
	logic              id_we;
	logic [ADDR_W-1:0] addr_inc;
	logic [3:0]        sel_type;

	// Bus condition toggles, clocked by the data pin itself
	logic start_tgl = 1'b0;
	logic stop_tgl  = 1'b0;

	// System domain state
	logic             stop_m1, stop_m2, stop_m3;
	logic             start_m1, start_m2, start_m3;
	logic             armed_m1, armed_m2;
	logic [CNT_W-1:0] wr_cnt;
	logic             stop_evt;
	logic             start_evt;

	// Start and stop are the only sda edges while scl is high
	always_ff @(negedge sda_in) begin
		if (scl)
			start_tgl <= ~start_tgl;
	end

	always_ff @(posedge sda_in) begin
		if (scl)
			stop_tgl <= ~stop_tgl;
	end

	// Pin and cross-domain levels into the link domain
	always_ff @(posedge scl) begin
		por_l1  <= srst;
		por_l2  <= por_l1;
		busy_l1 <= write_busy;
		busy_l2 <= busy_l1;
		wi_l1   <= write_inhibit_in;
		wi_l2   <= wi_l1;
		cs_l1   <= {chip_select_pin_high, chip_select_pin_low};
		cs_l2   <= cs_l1;
	end

	// Start toggle is settled a full hold time before scl falls
	always_ff @(negedge scl) begin
		if (por_l2) begin
			start_last <= start_tgl;
			start_seen <= 1'b0;
		end else begin
			start_last <= start_tgl;
			start_seen <= (start_tgl != start_last);
		end
	end

	assign sel_type = shreg[SEL_TYPE_HI:SEL_TYPE_LO];
	assign addr_inc = addr + 17'h0_0001;

	always_comb begin
		// Open pins arrive as zero, matching an unstrapped device
		sel_ok = (shreg[SEL_CS_HI:SEL_CS_LO] == cs_l2)
			&& ((sel_type == TYPE_MEM)
			|| (ID_PAGE && sel_type == TYPE_ID));
		wr_ok  = !wi_l2 && !(sel_id && id_lock);
		case (state)
			ST_SEL:     ack_now = sel_ok;
			ST_ADDR_HI: ack_now = 1'b1;
			ST_ADDR_LO: ack_now = 1'b1;
			ST_WDATA:   ack_now = wr_ok;
			default:    ack_now = 1'b0;
		endcase
	end

	// Storage uses the inhibit level latched when the ack was driven
	assign mem_we = (state == ST_WDATA) && (bit_cnt == BIT_ACK)
		&& !start_seen && !por_l2 && !busy_l2
		&& !wi_ack && !sel_id;
	assign id_we  = (state == ST_WDATA) && (bit_cnt == BIT_ACK)
		&& !start_seen && !por_l2 && !busy_l2
		&& !wi_ack && sel_id && !id_lock;

	always_ff @(posedge scl) begin
		if (mem_we)
			mem[addr] <= shreg;
		if (id_we)
			idp[addr[PAGE_W-1:0]] <= shreg;
	end

	// Bit engine: capture on rising scl
	always_ff @(posedge scl) begin
		if (por_l2 || busy_l2) begin
			state    <= ST_IDLE;
			bit_cnt  <= BIT_ZERO;
			shreg    <= RST_BYTE;
			wr_armed <= 1'b0;
			if (por_l2) begin
				addr    <= RST_ADDR;
				sel_id  <= 1'b0;
				id_lock <= 1'b0;
				rd_byte <= RST_BYTE;
			end
		end else if (start_seen) begin
			state    <= ST_SEL;
			shreg    <= {7'h00, sda_in};
			bit_cnt  <= BIT_FIRST;
			wr_armed <= 1'b0;
		end else if (state == ST_IDLE) begin
			bit_cnt <= BIT_ZERO;
		end else if (bit_cnt != BIT_ACK) begin
			if (state != ST_RDATA)
				shreg <= {shreg[DATA_W-2:0], sda_in};
			if (state == ST_WDATA && bit_cnt != BIT_ZERO)
				wr_armed <= 1'b0;  // A stop's scl rise lands on bit zero
			bit_cnt <= bit_cnt + BIT_FIRST;
		end else begin
			bit_cnt <= BIT_ZERO;
			case (state)
				ST_SEL: begin
					if (!sel_ok) begin
						state <= ST_IDLE;
					end else if (shreg[SEL_RW]) begin
						state  <= ST_RDATA;
						sel_id <= (sel_type == TYPE_ID);
						if (sel_type == TYPE_ID)
							rd_byte <= idp[addr[PAGE_W-1:0]];
						else
							rd_byte <= mem[addr];
					end else begin
						state     <= ST_ADDR_HI;
						sel_id    <= (sel_type == TYPE_ID);
						addr[16]  <= shreg[SEL_A16];
					end
				end
				ST_ADDR_HI: begin
					addr[15:8] <= shreg;
					state      <= ST_ADDR_LO;
				end
				ST_ADDR_LO: begin
					addr[7:0] <= shreg;
					state     <= ST_WDATA;
				end
				ST_WDATA: begin
					if (!wi_ack && !(sel_id && id_lock)) begin
						wr_armed <= 1'b1;
						// Page roll-over keeps the upper bits
						addr[PAGE_W-1:0] <= addr_inc[PAGE_W-1:0];
						if (sel_id && addr[ID_LOCK_BIT])
							id_lock <= 1'b1;
					end
				end
				ST_RDATA: begin
					if (!sda_in) begin
						addr <= addr_inc;
						if (sel_id)
							rd_byte <= idp[addr_inc[PAGE_W-1:0]];
						else
							rd_byte <= mem[addr_inc];
					end else begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Pin driver: change only after falling scl, pull low or release
	always_ff @(negedge scl) begin
		wi_ack <= wi_l2;
		if (por_l2 || busy_l2)
			sda_oe_n <= 1'b1;
		else if (start_seen)
			sda_oe_n <= 1'b1;
		else if (state == ST_RDATA && bit_cnt != BIT_ACK)
			sda_oe_n <= rd_byte[3'(7 - int'(bit_cnt))];
		else if (bit_cnt == BIT_ACK)
			sda_oe_n <= ~ack_now;
		else
			sda_oe_n <= 1'b1;
	end

	// Open drain: the driven level is always low
	always_ff @(posedge mclk) begin
		sda_out <= 1'b0;
	end

	// System domain: stop, start and armed cross in by two flops
	always_ff @(posedge mclk) begin
		stop_m1  <= stop_tgl;
		stop_m2  <= stop_m1;
		stop_m3  <= stop_m2;
		start_m1 <= start_tgl;
		start_m2 <= start_m1;
		start_m3 <= start_m2;
		armed_m1 <= wr_armed;
		armed_m2 <= armed_m1;
	end

	assign stop_evt  = stop_m2 ^ stop_m3;
	assign start_evt = start_m2 ^ start_m3;

	// Write cycle timer; a stop at any other slot leaves it idle
	always_ff @(posedge mclk) begin
		if (srst) begin
			write_busy <= 1'b0;
			wr_cnt     <= '0;
		end else if (write_busy) begin
			if (wr_cnt == CNT_W'(WR_CYC - 1)) begin
				write_busy <= 1'b0;
				wr_cnt     <= '0;
			end else begin
				wr_cnt <= wr_cnt + CNT_W'(1);
			end
		end else if (stop_evt && armed_m2) begin
			write_busy <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			standby <= 1'b1;
		else if (stop_evt && !armed_m2 && !write_busy)
			standby <= 1'b1;
		else if (write_busy && wr_cnt == CNT_W'(WR_CYC - 1))
			standby <= 1'b1;
		else if (start_evt || (stop_evt && armed_m2))
			standby <= 1'b0;
	end

	// Checks, link domain
	sequence s_data_ack_inhibit;
		state == ST_WDATA && bit_cnt == BIT_ACK && wi_l2 && !start_seen;
	endsequence

	sequence s_addr_ack;
		(state == ST_ADDR_HI || state == ST_ADDR_LO)
			&& bit_cnt == BIT_ACK && !start_seen && !busy_l2;
	endsequence

	property p_sel_mismatch;
		@(posedge scl) disable iff (por_l2)
		(state == ST_SEL && bit_cnt == BIT_ACK && !sel_ok
			&& !start_seen && !busy_l2) |=> (state == ST_IDLE);
	endproperty
	a_sel_mismatch: assert property (p_sel_mismatch)
		else $error("mismatched select did not go idle");

	property p_store_gate;
		@(posedge scl) disable iff (por_l2)
		mem_we |-> (!sda_oe_n && !wi_ack && !sel_id);
	endproperty
	a_store_gate: assert property (p_store_gate)
		else $error("array written while inhibited");

	property p_busy_idle;
		@(posedge scl) disable iff (por_l2)
		busy_l2 |=> (state == ST_IDLE) && !mem_we;
	endproperty
	a_busy_idle: assert property (p_busy_idle)
		else $error("engine active during write cycle");

	property p_busy_release;
		@(negedge scl) disable iff (por_l2)
		busy_l2 |=> sda_oe_n;
	endproperty
	a_busy_release: assert property (p_busy_release)
		else $error("data pin driven during write cycle");

	property p_inhibit_nack;
		@(negedge scl) disable iff (por_l2 || busy_l2)
		s_data_ack_inhibit |=> sda_oe_n && wi_ack;
	endproperty
	a_inhibit_nack: assert property (p_inhibit_nack)
		else $error("data byte acknowledged while inhibited");

	property p_addr_ack;
		@(negedge scl) disable iff (por_l2)
		s_addr_ack |=> !sda_oe_n;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address byte not acknowledged");

	// Checks, system domain
	sequence s_stop_armed;
		stop_evt && armed_m2 && !write_busy;
	endsequence

	property p_wr_start;
		@(posedge mclk) disable iff (srst)
		s_stop_armed |=> write_busy [*2] ##0 !standby;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("stop after data did not start write cycle");

	property p_stop_standby;
		@(posedge mclk) disable iff (srst)
		(stop_evt && !armed_m2 && !write_busy) |=> standby && !write_busy;
	endproperty
	a_stop_standby: assert property (p_stop_standby)
		else $error("stop did not enter standby");

	property p_por_quiet;
		@(posedge mclk)
		srst |=> (!write_busy && standby);
	endproperty
	a_por_quiet: assert property (p_por_quiet)
		else $error("power-on clear did not reset to standby");
endmodule

// ---- logic/eepfe_pkg.sv ----
// Purpose: Shared constants for the serial EEPROM pin front end
// Assumes: 20 MHz system clock, link clock taken from the bus master
// Notes:   Widths, select code layout and write cycle timing live here
package eepfe_pkg;
	localparam int ADDR_W      = 17;
	localparam int DATA_W      = 8;
	localparam int MEM_WORDS   = 131072;
	localparam int ID_WORDS    = 256;
	localparam int PAGE_W      = 8;
	localparam int BIT_W       = 4;

	// Select byte layout, most significant bit first on the wire
	localparam int SEL_TYPE_HI = 7;
	localparam int SEL_TYPE_LO = 4;
	localparam int SEL_CS_HI   = 3;
	localparam int SEL_CS_LO   = 2;
	localparam int SEL_A16     = 1;
	localparam int SEL_RW      = 0;
	localparam logic [3:0] TYPE_MEM = 4'hA;
	localparam logic [3:0] TYPE_ID  = 4'hB;

	// Identification page address bit that requests the lock, held until the next power-on clear
	localparam int ID_LOCK_BIT = 10;

	// Bit counter values of the acknowledge slot, the first bit and zero
	localparam logic [BIT_W-1:0] BIT_ACK   = 4'h8;
	localparam logic [BIT_W-1:0] BIT_FIRST = 4'h1;
	localparam logic [BIT_W-1:0] BIT_ZERO  = 4'h0;

	// Reset values
	localparam logic [ADDR_W-1:0] RST_ADDR = 17'h0_0000;
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

	// Internal write cycle, longest time rounded down to cycles
	localparam int CLK_PERIOD_NS = 50;
	localparam int WR_TIME_NS    = 5000000;
	localparam int WR_CYCLES     = WR_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA
	} eepfe_state_t;
endpackage

// ---- sim/eepfe_master.sv ----
// Purpose: Behavioural two-wire bus master facing the EEPROM front end
// Assumes: 125 ns bit period, pull-up on the data wire
// Notes:   Clock stands high between frames; data moves only while low
`timescale 1ns/1ps
module eepfe_master (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Idle pulses with the wire high, so no start or stop is seen
	task automatic pulses(input int n);
		repeat (n) begin
			#62 scl = 1'b0;
			#63 scl = 1'b1;
		end
	endtask
	task automatic bit_io(input logic b, output logic r);
		#31 sda_drv = b;
		#31 scl = 1'b1;
		#31 r = sda;
		#32 scl = 1'b0;
	endtask
	task automatic start();
		if (scl === 1'b0) begin
			#31 sda_drv = 1'b1;
			#31 scl = 1'b1;
		end
		#31 sda_drv = 1'b0;
		#32 scl = 1'b0;
	endtask
	// Every frame ends here; the device enters standby unless a write is armed or running
	task automatic stop();
		#31 sda_drv = 1'b0;
		#31 scl = 1'b1;
		#31 sda_drv = 1'b1;
		#32;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = (r === 1'b0);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ---- sim/eeprom_i2c_pin_front_end_tb_top.sv ----
// Purpose: Self-checking bench for the EEPROM pin front end
// Assumes: Short write cycle of 40 mclk, pull-up on the data wire
// Notes:   Byte store model in associative arrays
`timescale 1ns/1ps
module eeprom_i2c_pin_front_end_tb_top;
	import eepfe_pkg::*;
	logic mclk;
	logic srst;
	logic chip_select_pin_low;
	logic chip_select_pin_high;
	logic write_inhibit_in;
	wire  scl;
	wire  sda_drv;
	wire  sda_out;
	wire  sda_oe_n;
	wire  write_busy;
	wire  standby;
	wire  sda = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
	int   n_errors;
	int   n_checks;
	int   seed;
	logic [7:0] mem [int];
	logic [7:0] idp [int];

	eepfe_master u_eepfe_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	eepfe_front_end #(.WR_CYC(40)) u_eepfe_front_end (
		.mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.chip_select_pin_low(chip_select_pin_low),
		.chip_select_pin_high(chip_select_pin_high),
		.write_inhibit_in(write_inhibit_in),
		.write_busy(write_busy), .standby(standby));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk1(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t read %h exp %h", $time, got, exp);
		end
	endtask
	task automatic drive(input logic h, input logic l, input logic w);
		@(posedge mclk);
		#2;
		chip_select_pin_high = h;
		chip_select_pin_low = l;
		write_inhibit_in = w;
	endtask
	task automatic wait_busy(input logic v);
		int k;
		k = 0;
		while (write_busy !== v && k < 400) begin
			@(posedge mclk);
			#2;
			k++;
		end
		if (k == 400) begin
			n_errors++;
			$display("ERROR %0t write busy wait ran out", $time);
			wrap_up();
		end
	endtask
	function automatic logic [7:0] sel(logic [3:0] tp, logic a16, logic rw);
		return {tp, chip_select_pin_high, chip_select_pin_low, a16, rw};
	endfunction
	task automatic head(input logic [3:0] tp, input logic [16:0] a);
		logic k;
		u_eepfe_master.start();
		u_eepfe_master.wbyte(sel(tp, a[16], 1'b0), k);
		chk1(k, 1'b1, "select nack");
		u_eepfe_master.wbyte(a[15:8], k);
		chk1(k, 1'b1, "addr nack");
		u_eepfe_master.wbyte(a[7:0], k);
		chk1(k, 1'b1, "addr nack");
	endtask
	task automatic wr(input logic [3:0] tp, input logic [16:0] a,
		input logic [7:0] d);
		logic k;
		head(tp, a);
		u_eepfe_master.wbyte(d, k);
		chk1(k, ~write_inhibit_in, "data ack");
		u_eepfe_master.stop();
		if (!write_inhibit_in && tp == TYPE_ID)
			idp[a[7:0]] = d;
		else if (!write_inhibit_in)
			mem[a] = d;
		if (!write_inhibit_in) begin
			wait_busy(1'b1);
			chk1(standby, 1'b0, "standby in write");
		end else begin
			repeat (10) @(posedge mclk);
			chk1(write_busy, 1'b0, "write started");
		end
	endtask
	task automatic settle();
		wait_busy(1'b0);
		#2;
		chk1(standby, 1'b1, "no standby");
	endtask
	task automatic rd(input logic [3:0] tp, input logic [16:0] a);
		logic k;
		logic [7:0] d;
		head(tp, a);
		u_eepfe_master.start();
		u_eepfe_master.wbyte(sel(tp, a[16], 1'b1), k);
		chk1(k, 1'b1, "read select nack");
		u_eepfe_master.rbyte(1'b1, d);
		chk1(sda_out, 1'b0, "drive level");
		u_eepfe_master.stop();
		chk1(sda_oe_n, 1'b1, "not released");
		chk8(d, tp == TYPE_ID ? idp[a[7:0]] : mem[a]);
	endtask
	// A select byte that must be ignored
	task automatic refused(input logic [7:0] s, input string m);
		logic k;
		u_eepfe_master.start();
		u_eepfe_master.wbyte(s, k);
		chk1(k, 1'b0, m);
		u_eepfe_master.stop();
	endtask

	initial begin
		#3000000;
		n_errors++;
		$display("ERROR %0t run time limit reached", $time);
		wrap_up();
	end

	initial begin
		logic [16:0] a;
		logic [7:0]  d;
		seed = 56113;
		n_errors = 0;
		n_checks = 0;
		srst = 1'b1;
		chip_select_pin_low = 1'b0;
		chip_select_pin_high = 1'b0;
		write_inhibit_in = 1'b0;
		fork
			u_eepfe_master.pulses(8);
		join_none
		repeat (20) @(posedge mclk);
		#2 srst = 1'b0;
		u_eepfe_master.pulses(4);
		chk1(standby, 1'b1, "no standby");
		chk1(write_busy, 1'b0, "busy");
		// First pass keeps both pins low, as if left open
		for (int i = 0; i < 4; i++) begin
			a = $random(seed);
			d = $random(seed);
			drive(i > 0 && $random(seed), i > 0 && $random(seed), 1'b0);
			wr(TYPE_MEM, a, d);
			settle();
			rd(TYPE_MEM, a);
		end
		drive(chip_select_pin_high, chip_select_pin_low, 1'b1);
		wr(TYPE_MEM, a, ~d);
		rd(TYPE_MEM, a);
		drive(chip_select_pin_high, chip_select_pin_low, 1'b0);
		refused({TYPE_MEM, ~chip_select_pin_high, chip_select_pin_low,
			2'b00}, "foreign select acked");
		// The stop needs a few mclk to cross before standby shows it
		repeat (5) @(posedge mclk);
		#2;
		chk1(standby, 1'b1, "no standby");
		a = {9'h000, d};
		wr(TYPE_ID, a, ~d);
		settle();
		rd(TYPE_ID, a);
		wr(TYPE_MEM, a, d);
		refused(sel(TYPE_MEM, 1'b0, 1'b1), "acked while busy");
		chk1(sda_oe_n, 1'b1, "driven while busy");
		settle();
		drive(chip_select_pin_high, chip_select_pin_low, 1'b0);
		srst = 1'b1;
		u_eepfe_master.pulses(4);
		refused(sel(TYPE_MEM, 1'b0, 1'b1), "acked in clear");
		drive(chip_select_pin_high, chip_select_pin_low, 1'b0);
		srst = 1'b0;
		u_eepfe_master.pulses(4);
		chk1(standby, 1'b1, "no standby");
		rd(TYPE_MEM, a);
		wrap_up();
	end
endmodule
